// ### wdr_pkg.sv
// What this block does
// R1 - count on separate oscillator, not system clock
// R2 - refresh instruction clears the watchdog counter
// R3 - counter cleared while disabled and on reset
// R4 - expiry without refresh resets the whole chip
// R5 - prescale code doubles time-out from sixteen K
// R6 - fuse unprogrammed: level one, disabled after reset
// R7 - level one: enable bit set freely
// R8 - software follows timed sequence within four cycles
// R9 - fuse programmed: always enabled, reads one
// R10 - level two: timed sequence changes prescale only
// R11 - change enable self-clears four cycles later
// R12 - enable cleared only while change enable set
// R13 - prescale written only while change enable set
// R14 - control register layout, reset zero, reserved zero
// R15 - debug port reset sets flag, cleared by zero
// R16 - watchdog reset sets flag, cleared by zero
// R17 - brownout reset sets flag, cleared by zero
// R18 - pin reset sets flag, cleared by zero
// R19 - power-on flag set at power-on, software clears
// R20 - software reads then clears cause flags early
// R21 - expiry gives one cycle internal reset pulse
// R22 - window counted in system clocks, rewrite restarts
package wdr_pkg;

	// register byte addresses on the bus
	localparam logic [7:0] WDR_CTRL_ADDR = 8'h60;
	localparam logic [7:0] WDR_STAT_ADDR = 8'h64;

	// control register field positions
	localparam int WDR_CTRL_CE_BIT = 4;
	localparam int WDR_CTRL_EN_BIT = 3;
	localparam int WDR_CTRL_PS_LSB = 0;
	localparam int WDR_PS_W = 3;
	localparam logic [7:0] WDR_CTRL_RESET = 8'h00;

	// reset cause field positions
	localparam int WDR_STAT_DBG_BIT = 4;
	localparam int WDR_STAT_WDT_BIT = 3;
	localparam int WDR_STAT_BOR_BIT = 2;
	localparam int WDR_STAT_PIN_BIT = 1;
	localparam int WDR_STAT_POR_BIT = 0;
	localparam logic [4:0] WDR_STAT_RESET = 5'h01;

	// timed sequence window in system clock cycles
	localparam logic [2:0] WDR_WIN_CYCLES = 3'h4;

	// oscillator cycles at prescale code zero
	localparam int WDR_BASE_OSC_CYCLES = 16384;

	// index of each synchronised outside level
	localparam int WDR_IN_OSC = 0;
	localparam int WDR_IN_PIN = 1;
	localparam int WDR_IN_BOR = 2;
	localparam int WDR_IN_DBG = 3;
	localparam int WDR_N_IN = 4;

	typedef struct packed {
		logic ce;
		logic en;
		logic [WDR_PS_W-1:0] ps;
	} wdr_ctrl_t;

	typedef struct packed {
		logic dbg;
		logic wdt;
		logic bor;
		logic pin;
		logic por;
	} wdr_cause_t;

	typedef enum logic [0:0] {
		WDR_BUS_IDLE = 1'b0,
		WDR_BUS_ACK = 1'b1
	} wdr_bus_st_t;

endpackage

// ### wdr_counter.sv
`timescale 1ns/100ps
// watchdog counter advanced by oscillator ticks
module wdr_counter
#(
	parameter int BASE_CYCLES = 16384,
	parameter int PS_W = 3,
	parameter int CNT_W = 24
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic osc_tick,
	input wire logic clear,
	input wire logic [PS_W-1:0] prescale,
	output logic expire_q
);

	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] limit;

	// R5 time-out doubles per prescale step
	assign limit = CNT_W'(BASE_CYCLES) << prescale;

	// R1 counts oscillator ticks only; clear has priority
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			count_q <= '0;
		else if (clear || expire_q)
			count_q <= '0;
		else if (osc_tick)
			count_q <= count_q + CNT_W'(1);
	end

	// R4 expiry on the last tick of the period
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			expire_q <= 1'b0;
		else
			expire_q <= !clear && !expire_q && osc_tick &&
				(count_q == limit - CNT_W'(1));
	end

endmodule

// ### wdr_top.sv
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/100ps
// watchdog with reset cause flags, avalon-mm slave
module wdr_top
import wdr_pkg::*;
#(
	parameter int BASE_OSC_CYCLES = wdr_pkg::WDR_BASE_OSC_CYCLES,
	parameter int CNT_W = 24
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic wdt_osc,
	input wire logic always_on_fuse,
	input wire logic refresh_req,
	input wire logic pin_reset_in,
	input wire logic brownout_reset_in,
	input wire logic debug_reset_in,
	output logic wdt_reset_pulse,
	output logic wdt_running
);
	import wdr_pkg::*;

	logic [WDR_N_IN-1:0] sync1_q;
	logic [WDR_N_IN-1:0] sync2_q;
	logic [WDR_N_IN-1:0] last_q;
	logic osc_tick;
	logic src_rise_pin;
	logic src_rise_bor;
	logic src_rise_dbg;
	logic chip_reset;
	wdr_bus_st_t bus_q;
	logic wait_q;
	logic [31:0] rdata_q;
	logic commit_wr;
	logic take_req;
	logic [7:0] wbyte;
	logic wr_ctrl;
	logic wr_stat;
	wdr_ctrl_t wctl;
	logic level2_q;
	logic en_q;
	logic [WDR_PS_W-1:0] ps_q;
	logic ce_q;
	logic [2:0] win_q;
	logic open_seq;
	logic en_eff;
	wdr_cause_t cause_q;
	logic expire;
	logic pulse_q;
	logic run_q;
	logic [7:0] ctrl_rd;
	logic [7:0] stat_rd;

	// two-stage synchronisers for the oscillator and the three reset source levels
	genvar gi;
	generate
		for (gi = 0; gi < WDR_N_IN; gi++)
		begin : g_sync
			always_ff @(posedge sys_clk or negedge resetn)
			begin
				if (!resetn)
				begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
					last_q[gi] <= 1'b0;
				end
				else
				begin
					sync1_q[gi] <= (gi == WDR_IN_OSC) ? wdt_osc :
						(gi == WDR_IN_PIN) ? pin_reset_in :
						(gi == WDR_IN_BOR) ? brownout_reset_in :
						debug_reset_in;
					sync2_q[gi] <= sync1_q[gi];
					last_q[gi] <= sync2_q[gi];
				end
			end
		end
	endgenerate

	// R1 rising edge of the slow oscillator is one tick
	assign osc_tick = sync2_q[WDR_IN_OSC] && !last_q[WDR_IN_OSC];
	assign src_rise_pin = sync2_q[WDR_IN_PIN] && !last_q[WDR_IN_PIN];
	assign src_rise_bor = sync2_q[WDR_IN_BOR] && !last_q[WDR_IN_BOR];
	assign src_rise_dbg = sync2_q[WDR_IN_DBG] && !last_q[WDR_IN_DBG];

	// any chip reset other than power-on, held while a source is active
	assign chip_reset = pulse_q || sync2_q[WDR_IN_PIN] ||
		sync2_q[WDR_IN_BOR] || sync2_q[WDR_IN_DBG];

	// fuse is static; sampled after release so reset stays constant
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			level2_q <= 1'b0;
		else
			level2_q <= always_on_fuse;
	end

	// bus handshake: take request, answer one cycle later
	assign take_req = (avs_read || avs_write) && bus_q == WDR_BUS_IDLE;
	assign commit_wr = avs_write && bus_q == WDR_BUS_ACK;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			bus_q <= WDR_BUS_IDLE;
		else
		begin
			case (bus_q)
				WDR_BUS_IDLE:
					if (avs_read || avs_write)
						bus_q <= WDR_BUS_ACK;
				WDR_BUS_ACK:
					bus_q <= WDR_BUS_IDLE;
				default:
					bus_q <= WDR_BUS_IDLE;
			endcase
		end
	end

	// waitrequest stays high except in the answering cycle
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			wait_q <= 1'b1;
		else
			wait_q <= !take_req;
	end

	// only lane zero carries data; other lanes ignored
	assign wbyte = avs_writedata[7:0];
	assign wctl = wdr_ctrl_t'(wbyte[WDR_CTRL_CE_BIT:WDR_CTRL_PS_LSB]);

	// address decode; unmapped writes dropped
	always_comb
	begin
		wr_ctrl = 1'b0;
		wr_stat = 1'b0;
		if (commit_wr && avs_byteenable[0] && avs_address == WDR_CTRL_ADDR)
			wr_ctrl = 1'b1;
		else if (commit_wr && avs_byteenable[0] &&
			avs_address == WDR_STAT_ADDR)
			wr_stat = 1'b1;
	end

	// R7 R8 R10 a write of ones to change enable and enable opens window
	assign open_seq = wr_ctrl && wctl.ce && wctl.en;

	// R22 window counted in system clocks, restarted by a new opener
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			win_q <= '0;
		else if (chip_reset)
			win_q <= '0;
		else if (open_seq)
			win_q <= WDR_WIN_CYCLES;
		else if (wr_ctrl && ce_q)
			win_q <= '0;
		else if (win_q != '0)
			win_q <= win_q - 3'h1;
	end

	// R11 change enable drops four cycles after being set
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			ce_q <= WDR_CTRL_RESET[WDR_CTRL_CE_BIT];
		else if (chip_reset)
			ce_q <= WDR_CTRL_RESET[WDR_CTRL_CE_BIT];
		else if (open_seq)
			ce_q <= 1'b1;
		else if (wr_ctrl && ce_q)
			ce_q <= 1'b0;
		else if (win_q == 3'h1)
			ce_q <= 1'b0;
	end

	// enable bit, level one behaviour; level two forces it on
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			en_q <= WDR_CTRL_RESET[WDR_CTRL_EN_BIT];
		else if (chip_reset)
			// R6 disabled again after any chip reset
			en_q <= WDR_CTRL_RESET[WDR_CTRL_EN_BIT];
		else if (wr_ctrl && wctl.en)
			// R7 setting enable needs no sequence
			en_q <= 1'b1;
		else if (wr_ctrl && ce_q)
			// R12 clearing only inside the window
			en_q <= 1'b0;
	end

	// R13 prescale taken only inside the window
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			ps_q <= WDR_CTRL_RESET[WDR_PS_W-1:0];
		else if (chip_reset)
			ps_q <= WDR_CTRL_RESET[WDR_PS_W-1:0];
		else if (wr_ctrl && ce_q && !wctl.ce)
			// R10 same update at level two, enable value ignored
			ps_q <= wctl.ps;
	end

	// R9 level two keeps the watchdog enabled whatever is written
	assign en_eff = en_q || level2_q;

	// R2 R3 counter cleared on refresh, while disabled, on chip reset
	wdr_counter #(
		.BASE_CYCLES(BASE_OSC_CYCLES),
		.PS_W(WDR_PS_W),
		.CNT_W(CNT_W)
	) u_counter (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.osc_tick(osc_tick),
		.clear(refresh_req || !en_eff || chip_reset),
		.prescale(ps_q),
		.expire_q(expire)
	);

	// R4 R21 expiry gives a single-cycle chip reset pulse
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			pulse_q <= 1'b0;
		else
			pulse_q <= expire && !pulse_q;
	end

	// enable state shown on a pin for the rest of the chip
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			run_q <= 1'b0;
		else
			run_q <= en_eff;
	end

	// cause flags: a set in the same cycle as a clear wins
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			// R19 power-on sets its own flag, others cleared
			cause_q <= wdr_cause_t'(WDR_STAT_RESET);
		else
		begin
			// R15 debug port reset
			if (src_rise_dbg)
				cause_q.dbg <= 1'b1;
			else if (wr_stat && !wbyte[WDR_STAT_DBG_BIT])
				cause_q.dbg <= 1'b0;
			// R16 watchdog reset
			if (pulse_q)
				cause_q.wdt <= 1'b1;
			else if (wr_stat && !wbyte[WDR_STAT_WDT_BIT])
				cause_q.wdt <= 1'b0;
			// R17 brownout reset
			if (src_rise_bor)
				cause_q.bor <= 1'b1;
			else if (wr_stat && !wbyte[WDR_STAT_BOR_BIT])
				cause_q.bor <= 1'b0;
			// R18 pin reset
			if (src_rise_pin)
				cause_q.pin <= 1'b1;
			else if (wr_stat && !wbyte[WDR_STAT_PIN_BIT])
				cause_q.pin <= 1'b0;
			// R19 only a written zero clears it
			if (wr_stat && !wbyte[WDR_STAT_POR_BIT])
				cause_q.por <= 1'b0;
		end
	end

	// R14 readback image, reserved bits zero
	assign ctrl_rd = {3'h0, ce_q, en_eff, ps_q};
	assign stat_rd = {3'h0, cause_q};

	// read data latched at take, stands in the answering cycle
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			rdata_q <= '0;
		else if (take_req && avs_read && avs_address == WDR_CTRL_ADDR)
			rdata_q <= {24'h0, ctrl_rd};
		else if (take_req && avs_read && avs_address == WDR_STAT_ADDR)
			rdata_q <= {24'h0, stat_rd};
		else if (take_req)
			rdata_q <= '0;
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign wdt_reset_pulse = pulse_q;
	assign wdt_running = run_q;

endmodule

// ### wdr_top_sva.sv
`timescale 1ns/100ps
// port-level checks of bus answers and the watchdog reset pulse
module wdr_top_sva
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic always_on_fuse,
	input wire logic wdt_reset_pulse,
	input wire logic wdt_running
);
	import wdr_pkg::*;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);
	logic rd_ok;
	// read answer cycle, address still held by the master
	assign rd_ok = !avs_waitrequest && avs_read;

	chk_pulse_one_cycle: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
		else $error("reset pulse wider than one cycle");
	chk_pulse_needs_run: assert property (wdt_reset_pulse |-> $past(wdt_running))
		else $error("reset pulse while watchdog stopped");
	chk_idle_no_expiry: assert property ((!wdt_running)[*4] |=> !wdt_reset_pulse)
		else $error("expiry while watchdog disabled");
	chk_lvl1_stops: assert property (wdt_reset_pulse && !always_on_fuse |-> ##[1:3] !wdt_running)
		else $error("watchdog still running after chip reset");
	chk_rsv_zero: assert property (avs_readdata[31:5] == 27'h0)
		else $error("reserved read bits not zero");
	chk_unmapped_zero: assert property (rd_ok && avs_address != WDR_CTRL_ADDR
		&& avs_address != WDR_STAT_ADDR |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_lvl2_en_read: assert property (rd_ok && avs_address == WDR_CTRL_ADDR
		&& always_on_fuse && $past(always_on_fuse, 3) |-> avs_readdata[3])
		else $error("enable reads zero at level two");
	chk_lvl1_rst_off: assert property (!always_on_fuse && $past(!resetn) |-> !wdt_running)
		else $error("watchdog running after power-on reset");
endmodule

bind wdr_top wdr_top_sva u_wdr_top_sva (.sys_clk, .resetn, .avs_address,
	.avs_read, .avs_readdata, .avs_waitrequest, .always_on_fuse,
	.wdt_reset_pulse, .wdt_running);

// ### wdr_top_tb.sv
`timescale 1ns/100ps
// self-checking bench for the watchdog and reset cause block
module wdr_top_tb;
	import wdr_pkg::*;
	localparam int BASE = 4;
	localparam logic [7:0] CTL = WDR_CTRL_ADDR;
	localparam logic [7:0] STA = WDR_STAT_ADDR;
	logic sys_clk = 0;
	logic resetn = 0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 0;
	logic avs_write = 0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic wdt_osc = 0;
	logic always_on_fuse = 0;
	logic refresh_req = 0;
	logic [2:0] rst_src = 3'h0;
	logic [3:0] be = 4'hF;
	logic wdt_reset_pulse;
	logic wdt_running;
	logic [7:0] cur;
	logic [7:0] wd;
	logic [31:0] q;
	int fail_count = 0;
	int num_checks = 0;
	int pulses = 0;
	int cyc = 0;
	int seed = 32'hac76;
	int k;
	int n;

	wdr_top #(.BASE_OSC_CYCLES(BASE)) u_wdr_top (.sys_clk(sys_clk),
		.resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(be), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .wdt_osc(wdt_osc),
		.always_on_fuse(always_on_fuse), .refresh_req(refresh_req),
		.pin_reset_in(rst_src[0]), .brownout_reset_in(rst_src[1]),
		.debug_reset_in(rst_src[2]), .wdt_reset_pulse(wdt_reset_pulse),
		.wdt_running(wdt_running));

	always #50 sys_clk = ~sys_clk;

	// count reset pulses; the cycle ceiling cuts a hang short
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (wdt_reset_pulse === 1'b1)
			pulses <= pulses + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			finish_test();
		end
	end

	task finish_test();
		if (fail_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			$display("MISMATCH %s exp %h got %h", nm, e, g);
			fail_count++;
		end
	endtask

	// request held until waitrequest low, then a gap edge
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		do
			@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task rd(input string nm, input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(nm, {24'h0, e}, q);
	endtask

	// oscillator at eight system clocks a period
	task tick(input int t);
		repeat (t)
		begin
			wdt_osc <= 1'b1;
			repeat (4) @(posedge sys_clk);
			wdt_osc <= 1'b0;
			repeat (4) @(posedge sys_clk);
		end
	endtask

	// control after a write with change enable clear
	function automatic logic [7:0] exp_ctrl(logic [7:0] c, logic [7:0] d);
		return {4'h0, c[3] | d[3], c[2:0]};
	endfunction

	initial
	begin
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		rd("ctrl", CTL, 8'h00);
		rd("cause", STA, 8'h01);
		rd("unmapped", 8'h61, 8'h00);
		// software reads the cause first, then clears it
		wr(STA, 8'h00);
		rd("por clear", STA, 8'h00);
		// a write with lane zero disabled must be dropped
		be <= 4'hE;
		wr(CTL, 8'h08);
		be <= 4'hF;
		rd("lane off", CTL, 8'h00);
		cur = 8'h00;
		// random writes outside the window
		repeat (12)
		begin
			wd = 8'($random(seed)) & 8'hEF;
			wr(CTL, wd);
			cur = exp_ctrl(cur, wd);
			rd("ctrl", CTL, cur);
		end
		wr(CTL, 8'h08);
		wr(CTL, 8'h18);
		// read taken on the fourth edge after the opener still sees it
		repeat (2) @(posedge sys_clk);
		rd("ce set", CTL, 8'h18 | cur[2:0]);
		wr(CTL, 8'h18);
		// read taken on the fifth edge after the opener sees it gone
		repeat (3) @(posedge sys_clk);
		rd("ce clear", CTL, 8'h08 | cur[2:0]);
		wr(CTL, 8'h00);
		rd("no disable", CTL, 8'h08 | cur[2:0]);
		// timed sequences with random enable and prescale
		repeat (6)
		begin
			wd = 8'($random(seed)) & 8'h0F;
			wr(CTL, 8'h18);
			wr(CTL, wd);
			rd("timed", CTL, wd);
		end
		wr(CTL, 8'h18);
		wr(CTL, 8'h18);
		wr(CTL, 8'h03);
		rd("restart", CTL, 8'h03);
		// expiry after the selected count, refresh delays it
		for (int p = 0; p < 3; p++)
		begin
			wr(STA, 8'h00);
			wr(CTL, 8'h18);
			wr(CTL, 8'h08 | 8'(p));
			n = BASE << p;
			k = pulses;
			tick(n - 1);
			refresh_req <= 1'b1;
			@(posedge sys_clk);
			refresh_req <= 1'b0;
			tick(n - 1);
			chk("early", k, pulses);
			tick(1);
			chk("expiry", k + 1, pulses);
			rd("ctrl cleared", CTL, 8'h00);
			rd("wdt flag", STA, 8'h08);
		end
		// each outside reset source sets its own flag
		wr(STA, 8'h00);
		wd = 8'h00;
		for (int i = 0; i < 3; i++)
		begin
			rst_src <= 3'(1 << i);
			repeat (4) @(posedge sys_clk);
			rst_src <= 3'h0;
			repeat (4) @(posedge sys_clk);
			wd = wd | ((i == 2) ? 8'h10 : 8'(2 << i));
			rd("cause", STA, wd);
		end
		wr(STA, 8'h0F);
		rd("flag clear", STA, 8'h06);
		// fuse programmed keeps the watchdog on
		always_on_fuse <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd("lvl2 en", CTL, 8'h08);
		wr(CTL, 8'h18);
		wr(CTL, 8'h02);
		rd("lvl2 ps", CTL, 8'h0A);
		wr(CTL, 8'h18);
		wr(CTL, 8'h00);
		rd("lvl2 off", CTL, 8'h08);
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		rd("por", STA, 8'h01);
		rd("lvl2 rst", CTL, 8'h08);
		finish_test();
	end
endmodule
